// ---- core/trc_pkg.sv ----
// Shared constants and types of the small 8-bit core datapath.
// Assumes one 40 MHz system clock and an asynchronous active-high reset.
// Contract
// RULE1 - 32x8 register file, read-execute-write one cycle
// RULE2 - Registers 30/31 form the indirect pointer
// RULE3 - Next instruction prefetched while current executes
// RULE4 - 16-bit instruction words, relative reach 512
// RULE5 - Three-level 9-bit return stack
// RULE6 - Call or interrupt pushes, older entries sink
// RULE7 - Return pops level 0, others rise
// RULE8 - Overflow drops oldest, deepest level repeats
// RULE9 - Immediate instructions address only upper sixteen
// RULE10 - ALU does arithmetic, logic, bit ops
// RULE11 - Lowest vector address wins among pending
// RULE12 - Status register at I/O 0x3F, resets zero
// RULE13 - Global enable clear blocks every interrupt
// RULE14 - Accept clears global enable, return sets
// RULE15 - Bit store/load move bits via copy flag
// RULE16 - Sign flag equals negative xor overflow
// RULE17 - Zero, negative, carry flags from results
// RULE18 - Status register never saved on interrupt
// RULE19 - Sixty-four linear I/O locations
// RULE20 - 9-bit program counter, resets zero, wraps
package trc_pkg;
    localparam int DATA_W = 8;
    localparam int INSTR_W = 16;
    localparam int PC_W = 9;
    localparam int REG_COUNT = 32;
    localparam int STACK_DEPTH = 3;
    localparam int IO_ADDR_W = 6;
    localparam int IRQ_COUNT = 4;
    localparam logic [4:0] REG_R0 = 5'h00;
    localparam logic [4:0] REG_PTR_LO = 5'h1e;
    localparam logic [4:0] REG_PTR_HI = 5'h1f;
    localparam logic [IO_ADDR_W-1:0] STATUS_IO_ADDR = 6'h3f;
    localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
    localparam logic [PC_W-1:0] RESET_PC = 9'h000;
    localparam logic [PC_W-1:0] PC_STEP = 9'h001;
    localparam logic [DATA_W-1:0] SIGNED_MIN = 8'h80;
    localparam logic [DATA_W-1:0] SIGNED_MAX = 8'h7f;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;
    typedef enum logic [4:0] {
        ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_OR, ALU_EOR, ALU_PASS,
        ALU_COM, ALU_NEG, ALU_SWAP, ALU_INC, ALU_DEC, ALU_ASR, ALU_LSR, ALU_ROR,
        ALU_BLD, ALU_BST
    } trc_alu_op_t;
    typedef enum logic [1:0] {
        ST_RUN = 2'h0,
        ST_FLASH_READ = 2'h1
    } trc_state_t;
endpackage

// ---- core/trc_alu_if.sv ----
// Operand and result bundle between the core and its ALU.
// Assumes the ALU is purely combinational.
`timescale 1ns/1ps
`default_nettype none
interface trc_alu_if;
    import trc_pkg::*;
    trc_alu_op_t op;
    logic [DATA_W-1:0] a;
    logic [DATA_W-1:0] b;
    logic [DATA_W-1:0] flags_in;
    logic [DATA_W-1:0] res;
    logic [DATA_W-1:0] flags_out;
    modport core (output op, output a, output b, output flags_in, input res, input flags_out);
    modport alu (input op, input a, input b, input flags_in, output res, output flags_out);
endinterface
`default_nettype wire

// ---- core/trc_alu.sv ----
// Combinational ALU: result and new status flags for one operation.
// Assumes the core decides whether result and flags are kept.
`timescale 1ns/1ps
`default_nettype none
module trc_alu
    import trc_pkg::*;
(
    trc_alu_if.alu bus
);
    always_comb begin
        logic [DATA_W:0] wide;
        logic [4:0] nib;
        logic [DATA_W-1:0] r;
        logic [DATA_W-1:0] f;
        logic cin;
        logic cuse;
        cin = bus.flags_in[FLAG_C];
        cuse = (bus.op == ALU_ADC || bus.op == ALU_SBC) ? cin : 1'b0;
        f = bus.flags_in;
        wide = {1'b0, bus.a} + {1'b0, bus.b} + {8'h00, cuse};
        nib = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]} + {4'h0, cuse};
        r = bus.a;
        // RULE10 arithmetic logic bits
        case (bus.op)
            ALU_ADD, ALU_ADC: begin
                r = wide[DATA_W-1:0];
                f[FLAG_H] = nib[4];
                f[FLAG_C] = wide[DATA_W];
                f[FLAG_V] = (bus.a[7] == bus.b[7]) && (r[7] != bus.a[7]);
            end
            ALU_SUB, ALU_SBC: begin
                wide = {1'b0, bus.a} - {1'b0, bus.b} - {8'h00, cuse};
                nib = {1'b0, bus.a[3:0]} - {1'b0, bus.b[3:0]} - {4'h0, cuse};
                r = wide[DATA_W-1:0];
                f[FLAG_H] = nib[4];
                f[FLAG_C] = wide[DATA_W];
                f[FLAG_V] = (bus.a[7] != bus.b[7]) && (r[7] != bus.a[7]);
            end
            ALU_AND: begin r = bus.a & bus.b; f[FLAG_V] = 1'b0; end
            ALU_OR: begin r = bus.a | bus.b; f[FLAG_V] = 1'b0; end
            ALU_EOR: begin r = bus.a ^ bus.b; f[FLAG_V] = 1'b0; end
            ALU_PASS: r = bus.b;
            ALU_COM: begin r = ~bus.a; f[FLAG_C] = 1'b1; f[FLAG_V] = 1'b0; end
            ALU_NEG: begin
                r = BYTE_ZERO - bus.a;
                f[FLAG_C] = (r != BYTE_ZERO);
                f[FLAG_V] = (r == SIGNED_MIN);
                f[FLAG_H] = r[3] | bus.a[3];
            end
            ALU_SWAP: r = {bus.a[3:0], bus.a[7:4]};
            ALU_INC: begin r = bus.a + BYTE_ONE; f[FLAG_V] = (r == SIGNED_MIN); end
            ALU_DEC: begin r = bus.a - BYTE_ONE; f[FLAG_V] = (r == SIGNED_MAX); end
            ALU_ASR: begin r = {bus.a[7], bus.a[7:1]}; f[FLAG_C] = bus.a[0]; end
            ALU_LSR: begin r = {1'b0, bus.a[7:1]}; f[FLAG_C] = bus.a[0]; end
            ALU_ROR: begin r = {cin, bus.a[7:1]}; f[FLAG_C] = bus.a[0]; end
            // RULE15 copy flag load
            ALU_BLD: r[bus.b[2:0]] = bus.flags_in[FLAG_T];
            // RULE15 copy flag store
            ALU_BST: f[FLAG_T] = bus.a[bus.b[2:0]];
            default: r = bus.a;
        endcase
        if (!(bus.op inside {ALU_PASS, ALU_SWAP, ALU_BLD, ALU_BST})) begin
            // RULE17 zero negative carry
            f[FLAG_N] = r[7];
            // Subtract-with-carry chains keep zero only when every byte was zero
            f[FLAG_Z] = (r == BYTE_ZERO) && (bus.op != ALU_SBC || bus.flags_in[FLAG_Z]);
            if (bus.op inside {ALU_ASR, ALU_LSR, ALU_ROR}) begin
                f[FLAG_V] = f[FLAG_N] ^ f[FLAG_C];
            end
            // RULE16 sign from N, V
            f[FLAG_S] = f[FLAG_N] ^ f[FLAG_V];
        end
        bus.res = r;
        bus.flags_out = f;
    end
endmodule
`default_nettype wire

// ---- core/trc_ret_stack.sv ----
// Three-level hardware return stack of program counter values.
// Assumes push and pop never arrive in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module trc_ret_stack
    import trc_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic push_in,
    input wire logic pop_in,
    input wire logic [PC_W-1:0] push_addr_in,
    output logic [PC_W-1:0] top_out
);
    logic [PC_W-1:0] level [STACK_DEPTH];
    genvar i;
    generate
        for (i = 0; i < STACK_DEPTH; i++) begin : g_level
            logic [PC_W-1:0] from_above;
            logic [PC_W-1:0] from_below;
            if (i == 0) begin : g_top
                assign from_above = push_addr_in;
            end else begin : g_mid
                assign from_above = level[i-1];
            end
            // RULE8 deepest level keeps value
            if (i == STACK_DEPTH - 1) begin : g_deep
                assign from_below = level[i];
            end else begin : g_up
                assign from_below = level[i+1];
            end
            always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    level[i] <= RESET_PC;
                // RULE6 push sinks entries
                end else if (push_in) begin
                    level[i] <= from_above;
                // RULE7 pop raises entries
                end else if (pop_in) begin
                    level[i] <= from_below;
                end
            end
        end
    endgenerate
    assign top_out = level[0];
endmodule
`default_nettype wire

// ---- core/trc_core.sv ----
// Core datapath: fetch/execute pipeline, register file, status flags.
// Assumes synchronous program memory (word valid one cycle after address)
// and a combinational I/O read port.
`timescale 1ns/1ps
`default_nettype none
module trc_core
    import trc_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    output logic [PC_W-1:0] prog_addr_out,
    input wire logic [INSTR_W-1:0] prog_data_in,
    output logic [IO_ADDR_W-1:0] io_addr_out,
    output logic [DATA_W-1:0] io_wdata_out,
    output logic io_wr_out,
    output logic io_rd_out,
    input wire logic [DATA_W-1:0] io_rdata_in,
    input wire logic [IRQ_COUNT-1:0] irq_pending_in,
    output logic [IRQ_COUNT-1:0] irq_ack_out,
    output logic [DATA_W-1:0] status_flags_out,
    output logic [PC_W-1:0] program_counter_out
);
    trc_alu_if alu_bus ();
    logic [DATA_W-1:0] regs [REG_COUNT];
    logic [DATA_W-1:0] cpu_status_flags;
    logic [DATA_W-1:0] next_status;
    logic [PC_W-1:0] program_counter;
    logic [PC_W-1:0] exec_pc;
    logic ir_valid;
    trc_state_t state;
    logic [INSTR_W-1:0] ir;
    logic exec_go;
    logic take_irq;
    logic [IRQ_COUNT-1:0] irq_sel;
    logic [PC_W-1:0] irq_vector;
    logic [4:0] rd_idx;
    logic [4:0] rr_idx;
    logic [4:0] imm_idx;
    logic [4:0] wr_idx;
    logic [DATA_W-1:0] imm8;
    logic [IO_ADDR_W-1:0] io_a;
    logic [DATA_W-1:0] ptr_lo;
    logic [DATA_W-1:0] ptr_hi;
    logic [PC_W-1:0] rel_target;
    logic [PC_W-1:0] br_target;
    logic [PC_W-1:0] stack_top;
    logic wr_en;
    logic flags_en;
    logic do_jump;
    logic do_call;
    logic do_ret;
    logic do_interrupt_return_instr;
    logic do_lpm;
    logic is_in;
    logic is_out;
    logic is_bset;
    logic is_bclr;
    logic [PC_W-1:0] jump_target;
    logic [DATA_W-1:0] flash_byte;

    assign ir = prog_data_in;
    assign rd_idx = ir[8:4];
    assign rr_idx = {ir[9], ir[3:0]};
    // RULE9 immediates reach upper half
    assign imm_idx = {1'b1, ir[7:4]};
    assign imm8 = {ir[11:8], ir[3:0]};
    // RULE19 six-bit linear I/O address
    assign io_a = {ir[10:9], ir[3:0]};
    // RULE2 pointer pair
    assign ptr_lo = regs[REG_PTR_LO];
    assign ptr_hi = regs[REG_PTR_HI];
    // RULE4 relative reach wraps 512
    assign rel_target = exec_pc + PC_STEP + ir[PC_W-1:0];
    assign br_target = exec_pc + PC_STEP + {{2{ir[9]}}, ir[9:3]};
    assign flash_byte = ptr_lo[0] ? prog_data_in[15:8] : prog_data_in[7:0];

    // RULE13 global enable gates all
    assign take_irq = (state == ST_RUN) && ir_valid && cpu_status_flags[FLAG_I]
        && (irq_pending_in != '0);
    assign exec_go = (state == ST_RUN) && ir_valid && !take_irq;

    // RULE11 lowest vector wins
    always_comb begin
        irq_sel = '0;
        irq_vector = RESET_PC;
        for (int k = IRQ_COUNT - 1; k >= 0; k--) begin
            if (irq_pending_in[k]) begin
                irq_sel = '0;
                irq_sel[k] = 1'b1;
                irq_vector = PC_W'(k + 1);
            end
        end
    end
    assign irq_ack_out = take_irq ? irq_sel : '0;

    // Instruction decode; unknown words act as no-operation
    always_comb begin
        alu_bus.op = ALU_PASS;
        alu_bus.a = regs[rd_idx];
        alu_bus.b = regs[rr_idx];
        wr_idx = rd_idx;
        wr_en = 1'b0;
        flags_en = 1'b0;
        do_jump = 1'b0;
        do_call = 1'b0;
        do_ret = 1'b0;
        do_interrupt_return_instr = 1'b0;
        do_lpm = 1'b0;
        is_in = 1'b0;
        is_out = 1'b0;
        is_bset = 1'b0;
        is_bclr = 1'b0;
        jump_target = rel_target;
        casez (ir)
            // RULE1 two operands one cycle
            16'b0000_01??_????_????: begin alu_bus.op = ALU_SBC; flags_en = 1'b1; end
            16'b0000_10??_????_????: begin alu_bus.op = ALU_SBC; flags_en = 1'b1; wr_en = 1'b1; end
            16'b0000_11??_????_????: begin alu_bus.op = ALU_ADD; flags_en = 1'b1; wr_en = 1'b1; end
            16'b0001_01??_????_????: begin alu_bus.op = ALU_SUB; flags_en = 1'b1; end
            16'b0001_10??_????_????: begin alu_bus.op = ALU_SUB; flags_en = 1'b1; wr_en = 1'b1; end
            16'b0001_11??_????_????: begin alu_bus.op = ALU_ADC; flags_en = 1'b1; wr_en = 1'b1; end
            16'b0010_00??_????_????: begin alu_bus.op = ALU_AND; flags_en = 1'b1; wr_en = 1'b1; end
            16'b0010_01??_????_????: begin alu_bus.op = ALU_EOR; flags_en = 1'b1; wr_en = 1'b1; end
            16'b0010_10??_????_????: begin alu_bus.op = ALU_OR; flags_en = 1'b1; wr_en = 1'b1; end
            16'b0010_11??_????_????: wr_en = 1'b1;
            16'b0011_????_????_????,
            16'b0100_????_????_????,
            16'b0101_????_????_????,
            16'b0110_????_????_????,
            16'b0111_????_????_????,
            16'b1110_????_????_????: begin
                // RULE9 constant forms use upper registers
                alu_bus.a = regs[imm_idx];
                alu_bus.b = imm8;
                wr_idx = imm_idx;
                wr_en = (ir[15:12] != 4'h3);
                flags_en = (ir[15:12] != 4'he);
                case (ir[15:12])
                    4'h3: alu_bus.op = ALU_SUB;
                    4'h4: alu_bus.op = ALU_SBC;
                    4'h5: alu_bus.op = ALU_SUB;
                    4'h6: alu_bus.op = ALU_OR;
                    4'h7: alu_bus.op = ALU_AND;
                    default: alu_bus.op = ALU_PASS;
                endcase
            end
            16'b1000_000?????0000: begin
                // RULE2 high byte ignored
                alu_bus.b = regs[ptr_lo[4:0]];
                wr_en = 1'b1;
            end
            16'b1000_001?????0000: begin
                alu_bus.b = regs[rd_idx];
                wr_idx = ptr_lo[4:0];
                wr_en = 1'b1;
            end
            16'b1001_0100_0???1000: is_bset = 1'b1;
            16'b1001_0100_1???1000: is_bclr = 1'b1;
            16'b1001_0101_0000_1000: do_ret = 1'b1;
            16'b1001_0101_0001_1000: begin do_ret = 1'b1; do_interrupt_return_instr = 1'b1; end
            // RULE2 pointer reads flash
            16'b1001_0101_1100_1000: do_lpm = 1'b1;
            16'b1001_010?????0000: begin alu_bus.op = ALU_COM; flags_en = 1'b1; wr_en = 1'b1; end
            16'b1001_010?????0001: begin alu_bus.op = ALU_NEG; flags_en = 1'b1; wr_en = 1'b1; end
            16'b1001_010?????0010: begin alu_bus.op = ALU_SWAP; wr_en = 1'b1; end
            16'b1001_010?????0011: begin alu_bus.op = ALU_INC; flags_en = 1'b1; wr_en = 1'b1; end
            16'b1001_010?????0101: begin alu_bus.op = ALU_ASR; flags_en = 1'b1; wr_en = 1'b1; end
            16'b1001_010?????0110: begin alu_bus.op = ALU_LSR; flags_en = 1'b1; wr_en = 1'b1; end
            16'b1001_010?????0111: begin alu_bus.op = ALU_ROR; flags_en = 1'b1; wr_en = 1'b1; end
            16'b1001_010?????1010: begin alu_bus.op = ALU_DEC; flags_en = 1'b1; wr_en = 1'b1; end
            16'b1011_0???_????_????: begin
                is_in = 1'b1;
                alu_bus.b = (io_a == STATUS_IO_ADDR) ? cpu_status_flags : io_rdata_in;
                wr_en = 1'b1;
            end
            16'b1011_1???_????_????: is_out = 1'b1;
            16'b1100_????_????_????: do_jump = 1'b1;
            16'b1101_????_????_????: begin do_jump = 1'b1; do_call = 1'b1; end
            16'b1111_0???_????_????: begin
                do_jump = cpu_status_flags[ir[2:0]] ^ ir[10];
                jump_target = br_target;
            end
            16'b1111_100?????0???: begin
                alu_bus.op = ALU_BLD;
                alu_bus.b = {5'h00, ir[2:0]};
                wr_en = 1'b1;
            end
            16'b1111_101?????0???: begin
                alu_bus.op = ALU_BST;
                alu_bus.b = {5'h00, ir[2:0]};
                flags_en = 1'b1;
            end
            default: wr_en = 1'b0;
        endcase
        alu_bus.flags_in = cpu_status_flags;
    end

    trc_alu u_alu (
        .bus(alu_bus)
    );

    // RULE5 three-level return stack
    trc_ret_stack u_stack (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .push_in(take_irq || (exec_go && do_call)),
        .pop_in(exec_go && do_ret),
        .push_addr_in(take_irq ? exec_pc : program_counter),
        .top_out(stack_top)
    );

    // RULE1 write back same cycle
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            for (int k = 0; k < REG_COUNT; k++) begin
                regs[k] <= BYTE_ZERO;
            end
        end else if (state == ST_FLASH_READ) begin
            regs[REG_R0] <= flash_byte;
        end else if (exec_go && wr_en) begin
            regs[wr_idx] <= alu_bus.res;
        end
    end

    // Status update; later terms override earlier ones
    always_comb begin
        next_status = cpu_status_flags;
        if (exec_go && flags_en) begin
            next_status = alu_bus.flags_out;
        end
        if (exec_go && is_bset) begin
            next_status[ir[6:4]] = 1'b1;
        end
        if (exec_go && is_bclr) begin
            next_status[ir[6:4]] = 1'b0;
        end
        // RULE12 fully writable at 0x3F
        if (exec_go && is_out && io_a == STATUS_IO_ADDR) begin
            next_status = regs[rd_idx];
        end
        // RULE14 return re-enables
        if (exec_go && do_interrupt_return_instr) begin
            next_status[FLAG_I] = 1'b1;
        end
        // RULE14 acceptance clears enable
        if (take_irq) begin
            next_status[FLAG_I] = 1'b0;
        end
    end

    // RULE12 resets to zero
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cpu_status_flags <= STATUS_RESET;
        end else begin
            cpu_status_flags <= next_status;
        end
    end

    // RULE3 prefetch while executing
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            // RULE20 start at zero
            program_counter <= RESET_PC;
            exec_pc <= RESET_PC;
            ir_valid <= 1'b0;
            state <= ST_RUN;
        end else begin
            case (state)
                ST_FLASH_READ: begin
                    program_counter <= program_counter + PC_STEP;
                    exec_pc <= program_counter;
                    ir_valid <= 1'b1;
                    state <= ST_RUN;
                end
                ST_RUN: begin
                    if (take_irq) begin
                        // RULE18 flags left for software
                        program_counter <= irq_vector;
                        ir_valid <= 1'b0;
                    end else if (exec_go && do_ret) begin
                        // RULE7 resume from level 0
                        program_counter <= stack_top;
                        ir_valid <= 1'b0;
                    end else if (exec_go && do_jump) begin
                        program_counter <= jump_target;
                        ir_valid <= 1'b0;
                    end else if (exec_go && do_lpm) begin
                        // Flash port busy one cycle; fetch resumes after
                        ir_valid <= 1'b0;
                        state <= ST_FLASH_READ;
                    end else begin
                        // RULE20 wraps modulo 512
                        program_counter <= program_counter + PC_STEP;
                        exec_pc <= program_counter;
                        ir_valid <= 1'b1;
                    end
                end
                default: state <= ST_RUN;
            endcase
        end
    end

    assign prog_addr_out = (exec_go && do_lpm) ? {ptr_hi[0], ptr_lo[7:1]} : program_counter;
    assign io_addr_out = io_a;
    assign io_wdata_out = regs[rd_idx];
    assign io_wr_out = exec_go && is_out && (io_a != STATUS_IO_ADDR);
    assign io_rd_out = exec_go && is_in && (io_a != STATUS_IO_ADDR);
    assign status_flags_out = cpu_status_flags;
    assign program_counter_out = program_counter;
endmodule
`default_nettype wire

// ---- sim/trc_core_properties.sv ----
// Port-level assertions for the core datapath.
// Assumes one clock domain; bound to trc_core below.
`timescale 1ns/1ps
`default_nettype none
module trc_core_properties
    import trc_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic [PC_W-1:0] prog_addr_out,
    input wire logic [INSTR_W-1:0] prog_data_in,
    input wire logic [IO_ADDR_W-1:0] io_addr_out,
    input wire logic [DATA_W-1:0] io_wdata_out,
    input wire logic io_wr_out,
    input wire logic io_rd_out,
    input wire logic [DATA_W-1:0] io_rdata_in,
    input wire logic [IRQ_COUNT-1:0] irq_pending_in,
    input wire logic [IRQ_COUNT-1:0] irq_ack_out,
    input wire logic [DATA_W-1:0] status_flags_out,
    input wire logic [PC_W-1:0] program_counter_out
);
    logic [PC_W-1:0] ack_vec;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    // Vector of source k sits at k+1
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ack_vec <= 9'h000;
        end else begin
            ack_vec <= irq_ack_out[0] ? 9'h001 : irq_ack_out[1] ? 9'h002 :
                irq_ack_out[2] ? 9'h003 : 9'h004;
        end
    end
    a_ack_vector: assert property (irq_ack_out != 4'h0 |=> prog_addr_out == ack_vec)
        else $error("vector not fetched after acceptance");
    a_ack_lowest: assert property (irq_ack_out != 4'h0 |->
        irq_ack_out == (irq_pending_in & (~irq_pending_in + 4'h1)))
        else $error("acknowledged source is not the lowest pending");
    a_ack_pulse: assert property (irq_ack_out != 4'h0 |=> irq_ack_out == 4'h0)
        else $error("acknowledge longer than one cycle");
    a_ack_enabled: assert property (irq_ack_out != 4'h0 |-> status_flags_out[7])
        else $error("interrupt taken with global enable clear");
    a_enable_cleared: assert property (irq_ack_out != 4'h0 |=> !status_flags_out[7])
        else $error("global enable not cleared on acceptance");
    a_status_hidden: assert property ((io_wr_out || io_rd_out) |-> io_addr_out != 6'h3f)
        else $error("status location strobed on the I/O port");
    a_sign_xor: assert property (status_flags_out[4] ==
        (status_flags_out[2] ^ status_flags_out[3]))
        else $error("sign flag differs from negative xor overflow");
    a_reset_start: assert property ($past(sys_rst_in) |->
        prog_addr_out == 9'h000 && status_flags_out == 8'h00 && program_counter_out == 9'h000)
        else $error("fetch or status not at reset value after release");
endmodule
bind trc_core trc_core_properties i_props (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .prog_addr_out(prog_addr_out), .prog_data_in(prog_data_in), .io_addr_out(io_addr_out),
    .io_wdata_out(io_wdata_out), .io_wr_out(io_wr_out), .io_rd_out(io_rd_out),
    .io_rdata_in(io_rdata_in), .irq_pending_in(irq_pending_in), .irq_ack_out(irq_ack_out),
    .status_flags_out(status_flags_out), .program_counter_out(program_counter_out));
`default_nettype wire

// ---- sim/trc_env_model.sv ----
// Program flash, I/O space and interrupt sources facing the core.
// Assumes the bench loads mem after time zero; logs writes and acks.
`timescale 1ns/1ps
`default_nettype none
module trc_env_model
    import trc_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic [PC_W-1:0] prog_addr_in,
    output logic [INSTR_W-1:0] prog_data_out,
    input wire logic [IO_ADDR_W-1:0] io_addr_in,
    input wire logic [DATA_W-1:0] io_wdata_in,
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    output logic [DATA_W-1:0] io_rdata_out,
    input wire logic [IRQ_COUNT-1:0] irq_raise_in,
    input wire logic [IRQ_COUNT-1:0] irq_ack_in,
    output logic [IRQ_COUNT-1:0] irq_pending_out
);
    logic [INSTR_W-1:0] mem [0:511];
    logic [DATA_W-1:0] io_mem [0:63];
    logic [15:0] wr_log [$];
    logic [3:0] ack_log [$];
    initial foreach (mem[i]) mem[i] = 16'h0000;
    initial foreach (io_mem[i]) io_mem[i] = 8'h00;
    // Unstrobed reads show garbage, not the last value
    assign io_rdata_out = io_rd_in ? io_mem[io_addr_in] : ~io_mem[io_addr_in];
    always @(posedge clk_sys_in) begin
        prog_data_out <= mem[prog_addr_in];
        if (io_wr_in) begin
            io_mem[io_addr_in] <= io_wdata_in;
            wr_log.push_back({2'b00, io_addr_in, io_wdata_in});
        end
        if (irq_ack_in != 4'h0) begin
            ack_log.push_back(irq_ack_in);
        end
    end
    // Flag drops when its vector is taken
    always @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            irq_pending_out <= 4'h0;
        end else begin
            irq_pending_out <= (irq_pending_out | irq_raise_in) & ~irq_ack_in;
        end
    end
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench: runs a small program and checks I/O writes.
// Assumes trc_core, trc_env_model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) \
    comparisons++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("[FAIL] %0t got %h expected %h", $time, got, exp); \
    end
module tb
    import trc_pkg::*;
;
    localparam logic [15:0] PROG [0:49] = '{16'hC007, 16'hC03A, 16'hC039, 16'hC038,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hE005, 16'hEF1B, 16'h0F01, 16'hBB00,
        16'hB72F, 16'hBB21, 16'hE134, 16'hBF3F, 16'hB74F, 16'hBB42, 16'hFB17, 16'hF902,
        16'hBB03, 16'hE8E1, 16'hE0F0, 16'h95C8, 16'hBA07, 16'hE1E0, 16'hEFFF, 16'h8160,
        16'hBB69, 16'h94E8, 16'h9478, 16'hF7FE, 16'hD007, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hD002, 16'hBB06, 16'h9508, 16'hD002,
        16'hBB05, 16'h9508, 16'hD002, 16'hBB04, 16'h9508, 16'h9508};
    localparam logic [15:0] EXP_WR [0:9] = '{16'h1000, 16'h1123, 16'h1214, 16'h1304,
        16'h17A5, 16'h1904, 16'h1404, 16'h1504, 16'h1604, 16'h1604};
    logic clk_sys_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [IRQ_COUNT-1:0] irq_raise = 4'h0;
    logic [PC_W-1:0] prog_addr;
    logic [INSTR_W-1:0] prog_data;
    logic [IO_ADDR_W-1:0] io_addr;
    logic [DATA_W-1:0] io_wdata, io_rdata, status_flags;
    logic io_wr, io_rd;
    logic [IRQ_COUNT-1:0] irq_pending, irq_ack;
    int err_count = 0;
    int comparisons = 0;
    trc_core i_dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .prog_addr_out(prog_addr),
        .prog_data_in(prog_data), .io_addr_out(io_addr), .io_wdata_out(io_wdata),
        .io_wr_out(io_wr), .io_rd_out(io_rd), .io_rdata_in(io_rdata),
        .irq_pending_in(irq_pending), .irq_ack_out(irq_ack),
        .status_flags_out(status_flags), .program_counter_out());
    trc_env_model i_env (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
        .prog_addr_in(prog_addr), .prog_data_out(prog_data), .io_addr_in(io_addr),
        .io_wdata_in(io_wdata), .io_wr_in(io_wr), .io_rd_in(io_rd), .io_rdata_out(io_rdata),
        .irq_raise_in(irq_raise), .irq_ack_in(irq_ack), .irq_pending_out(irq_pending));
    task automatic check_wr(input int first, input int last);
        for (int i = first; i <= last; i++) begin
            `CHECK(i_env.wr_log[i], EXP_WR[i])
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    // Program needs well under 3000 cycles
    initial begin
        #150us;
        err_count++;
        conclude();
    end
    initial begin
        #1;
        for (int i = 0; i < 50; i++) i_env.mem[i] = PROG[i];
        i_env.mem[60] = 16'h9468;
        i_env.mem[61] = 16'h9518;
        i_env.mem[64] = 16'hA55A;
        repeat (20) @(posedge clk_sys_in);
        #2 sys_rst_in = 1'b0;
        // Raised while global enable is still clear
        @(posedge clk_sys_in);
        #2 irq_raise = 4'h7;
        @(posedge clk_sys_in);
        #2 irq_raise = 4'h0;
        for (int n = 0; n < 3000 && i_env.wr_log.size() < 10; n++) @(posedge clk_sys_in);
        check_wr(0, 1);
        check_wr(2, 2);
        check_wr(3, 3);
        check_wr(4, 5);
        $display("test alu, status, bit copy, pointer done");
        for (int i = 0; i < 3; i++) begin
            `CHECK(i_env.ack_log[i], 4'h1 << i)
        end
        `CHECK(status_flags[7:6], 2'b11)
        $display("test interrupts done");
        check_wr(6, 9);
        $display("test return stack done");
        conclude();
    end
endmodule
`default_nettype wire
